/* core/trim_pkg.sv */
// Constants and types for the offset and gain trim register bank
//----------------------------------------------------------------
// What this block does
// [R1] Core B input A offset applied when calibrating
// [R2] Core B input B offset applied when calibrating
// [R3] Offset choice ignores single or dual mode
// [R4] Dual mode: core A banks own gains
// [R5] Dual mode: core B banks own gains
// [R6] Trim defaults load from fuses after reset
// [R7] Upper reserved bits read-write, reset zero
//----------------------------------------------------------------
package trim_pkg;

	//------------------------------------------------------------
	// Widths
	//------------------------------------------------------------
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 8;
	localparam int NUM_BYTES = 8;
	localparam int FUSE_AW   = 3;
	localparam int OFS_W     = 12;
	localparam int GAIN_W    = 5;

	//------------------------------------------------------------
	// Register byte addresses
	//------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_OFS_INA_LO = 12'h34C;
	localparam logic [ADDR_W-1:0] ADDR_OFS_INA_HI = 12'h34D;
	localparam logic [ADDR_W-1:0] ADDR_OFS_INB_LO = 12'h34E;
	localparam logic [ADDR_W-1:0] ADDR_OFS_INB_HI = 12'h34F;
	localparam logic [ADDR_W-1:0] ADDR_GAIN_A0    = 12'h350;
	localparam logic [ADDR_W-1:0] ADDR_GAIN_A1    = 12'h351;
	localparam logic [ADDR_W-1:0] ADDR_GAIN_B0    = 12'h352;
	localparam logic [ADDR_W-1:0] ADDR_GAIN_B1    = 12'h353;
	localparam logic [ADDR_W-1:0] ADDR_STATUS     = 12'h35F;

	//------------------------------------------------------------
	// Byte slots in the bank
	//------------------------------------------------------------
	localparam logic [2:0] IDX_OFS_INA_LO = 3'h0;
	localparam logic [2:0] IDX_OFS_INA_HI = 3'h1;
	localparam logic [2:0] IDX_OFS_INB_LO = 3'h2;
	localparam logic [2:0] IDX_OFS_INB_HI = 3'h3;
	localparam logic [2:0] IDX_GAIN_A0    = 3'h4;
	localparam logic [2:0] IDX_GAIN_A1    = 3'h5;
	localparam logic [2:0] IDX_GAIN_B0    = 3'h6;
	localparam logic [2:0] IDX_GAIN_B1    = 3'h7;
	localparam logic [2:0] IDX_LAST       = 3'h7;

	//------------------------------------------------------------
	// Field masks and reset values
	//------------------------------------------------------------
	localparam logic [DATA_W-1:0] MASK_OFS_LO = 8'hFF;
	localparam logic [DATA_W-1:0] MASK_OFS_HI = 8'h0F;
	localparam logic [DATA_W-1:0] MASK_GAIN   = 8'h1F;
	localparam logic [DATA_W-1:0] RESET_BYTE  = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_MASK [NUM_BYTES] = '{
		MASK_OFS_LO, MASK_OFS_HI, MASK_OFS_LO, MASK_OFS_HI,
		MASK_GAIN, MASK_GAIN, MASK_GAIN, MASK_GAIN};

	//------------------------------------------------------------
	// Status fields
	//------------------------------------------------------------
	localparam int STATUS_DONE_BIT = 0;
	localparam int STATUS_BUSY_BIT = 1;

	//------------------------------------------------------------
	// Fuse loader states
	//------------------------------------------------------------
	typedef enum logic [1:0] {
		LOAD_START,
		LOAD_FETCH,
		LOAD_CAPTURE,
		LOAD_DONE
	} load_state_t;

endpackage

/* core/trim_byte_cell.sv */
// One byte of trim storage, written by the bus or by the fuse loader
`timescale 1ns/1ps
module trim_byte_cell #(
	parameter logic [7:0] FIELD_MASK = 8'hFF
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// Bus write
	input  wire logic       busWr,
	input  wire logic [7:0] busData,
	// Fuse write
	input  wire logic       fuseWr,
	input  wire logic [7:0] fuseData,
	// Stored byte
	output logic      [7:0] value
);
	import trim_pkg::*;

	typedef struct packed {
		logic [7:0] value;
	} cell_t;

	cell_t cell_ff;
	cell_t nxt_cell;

	always_comb begin
		nxt_cell = cell_ff;
		if (fuseWr) begin
			nxt_cell.value = fuseData & FIELD_MASK; // [R6] [R7]
		end else if (busWr) begin
			nxt_cell.value = busData; // [R7]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cell_ff.value <= RESET_BYTE; // [R7]
		end else begin
			cell_ff <= nxt_cell;
		end
	end

	assign value = cell_ff.value;

endmodule

/* core/trim_offset_gain_regs.sv */
// Offset and fine-gain trim register bank with fuse default load
`timescale 1ns/1ps
module trim_offset_gain_regs (
	// Clock and reset
	input  wire logic                            ref_clk,
	input  wire logic                            rst_b,
	// Register port
	input  wire logic [trim_pkg::ADDR_W-1:0]     regAddr,
	input  wire logic [trim_pkg::DATA_W-1:0]     regWrData,
	input  wire logic                            regWrStrobe,
	input  wire logic                            regRdStrobe,
	output logic      [trim_pkg::DATA_W-1:0]     regRdData,
	// Fuse storage
	output logic      [trim_pkg::FUSE_AW-1:0]    fuseAddr,
	output logic                                 fuseRd,
	input  wire logic [trim_pkg::DATA_W-1:0]     fuseData,
	// Converter mode
	input  wire logic                            fgCalEn,
	input  wire logic                            dualMode,
	input  wire logic                            coreBInB,
	// Corrections
	output logic      [trim_pkg::OFS_W-1:0]      coreBOffset,
	output logic      [trim_pkg::GAIN_W-1:0]     coreAGain0,
	output logic      [trim_pkg::GAIN_W-1:0]     coreAGain1,
	output logic      [trim_pkg::GAIN_W-1:0]     coreBGain0,
	output logic      [trim_pkg::GAIN_W-1:0]     coreBGain1,
	output logic                                 fuseLoadDone
);
	import trim_pkg::*;

	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		load_state_t         state;
		logic [2:0]          idx;
		logic                fuseRd;
		logic [FUSE_AW-1:0]  fuseAddr;
		logic                loadDone;
		logic [DATA_W-1:0]   rdData;
		logic [OFS_W-1:0]    coreBOffset;
		logic [GAIN_W-1:0]   gainA0;
		logic [GAIN_W-1:0]   gainA1;
		logic [GAIN_W-1:0]   gainB0;
		logic [GAIN_W-1:0]   gainB1;
	} regs_t;

	regs_t s_ff;
	regs_t nxt_s;

	logic [DATA_W-1:0]    trimByte [NUM_BYTES];
	logic [NUM_BYTES-1:0] busWr;
	logic [NUM_BYTES-1:0] fuseWr;
	logic                 hit;
	logic [2:0]           hitIdx;
	logic [OFS_W-1:0]     offA;
	logic [OFS_W-1:0]     offB;
	logic [DATA_W-1:0]    statusByte;

	//------------------------------------------------------------
	// Address decode
	//------------------------------------------------------------
	always_comb begin
		hit    = 1'b1;
		hitIdx = IDX_OFS_INA_LO;
		case (regAddr)
			ADDR_OFS_INA_LO: hitIdx = IDX_OFS_INA_LO;
			ADDR_OFS_INA_HI: hitIdx = IDX_OFS_INA_HI;
			ADDR_OFS_INB_LO: hitIdx = IDX_OFS_INB_LO;
			ADDR_OFS_INB_HI: hitIdx = IDX_OFS_INB_HI;
			ADDR_GAIN_A0:    hitIdx = IDX_GAIN_A0;
			ADDR_GAIN_A1:    hitIdx = IDX_GAIN_A1;
			ADDR_GAIN_B0:    hitIdx = IDX_GAIN_B0;
			ADDR_GAIN_B1:    hitIdx = IDX_GAIN_B1;
			default:         hit    = 1'b0;
		endcase
	end

	//------------------------------------------------------------
	// Trim storage
	//------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BYTES; gi++) begin : gCell
			assign busWr[gi]  = regWrStrobe && s_ff.loadDone && hit &&
				(hitIdx == 3'(gi));
			assign fuseWr[gi] = (s_ff.state == LOAD_CAPTURE) &&
				(s_ff.idx == 3'(gi));
			trim_byte_cell #(
				.FIELD_MASK (BYTE_MASK[gi])
			) uCell (
				.ref_clk  (ref_clk),
				.rst_b    (rst_b),
				.busWr    (busWr[gi]),
				.busData  (regWrData),
				.fuseWr   (fuseWr[gi]),
				.fuseData (fuseData),
				.value    (trimByte[gi])
			);
		end
	endgenerate

	assign offA = {trimByte[IDX_OFS_INA_HI][3:0], trimByte[IDX_OFS_INA_LO]};
	assign offB = {trimByte[IDX_OFS_INB_HI][3:0], trimByte[IDX_OFS_INB_LO]};

	always_comb begin
		statusByte = 8'h00;
		statusByte[STATUS_DONE_BIT] = s_ff.loadDone;
		statusByte[STATUS_BUSY_BIT] = !s_ff.loadDone;
	end

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		nxt_s        = s_ff;
		nxt_s.fuseRd = 1'b0;
		// Fuse loader
		case (s_ff.state)
			LOAD_START: begin
				nxt_s.fuseRd   = 1'b1; // [R6]
				nxt_s.fuseAddr = s_ff.idx;
				nxt_s.state    = LOAD_FETCH;
			end
			LOAD_FETCH: begin
				nxt_s.state = LOAD_CAPTURE;
			end
			LOAD_CAPTURE: begin
				if (s_ff.idx == IDX_LAST) begin
					nxt_s.loadDone = 1'b1; // [R6]
					nxt_s.state    = LOAD_DONE;
				end else begin
					nxt_s.idx      = s_ff.idx + 3'h1;
					nxt_s.fuseRd   = 1'b1;
					nxt_s.fuseAddr = s_ff.idx + 3'h1;
					nxt_s.state    = LOAD_FETCH;
				end
			end
			LOAD_DONE: begin
				nxt_s.state = LOAD_DONE;
			end
			default: begin
				nxt_s.state = LOAD_START;
			end
		endcase
		// Read data
		nxt_s.rdData = 8'h00;
		if (regRdStrobe) begin
			if (hit) begin
				nxt_s.rdData = trimByte[hitIdx]; // [R7]
			end else if (regAddr == ADDR_STATUS) begin
				nxt_s.rdData = statusByte;
			end
		end
		// Offset correction for core B
		if (!fgCalEn) begin
			nxt_s.coreBOffset = '0;
		end else if (coreBInB) begin
			nxt_s.coreBOffset = offB; // [R2] [R3]
		end else begin
			nxt_s.coreBOffset = offA; // [R1] [R3]
		end
		// Dual-mode fine gains
		if (fgCalEn && dualMode) begin
			nxt_s.gainA0 = trimByte[IDX_GAIN_A0][GAIN_W-1:0]; // [R4]
			nxt_s.gainA1 = trimByte[IDX_GAIN_A1][GAIN_W-1:0]; // [R4]
			nxt_s.gainB0 = trimByte[IDX_GAIN_B0][GAIN_W-1:0]; // [R5]
			nxt_s.gainB1 = trimByte[IDX_GAIN_B1][GAIN_W-1:0]; // [R5]
		end else begin
			nxt_s.gainA0 = '0;
			nxt_s.gainA1 = '0;
			nxt_s.gainB0 = '0;
			nxt_s.gainB1 = '0;
		end
	end

	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_ff.state       <= LOAD_START;
			s_ff.idx         <= 3'h0;
			s_ff.fuseRd      <= 1'b0;
			s_ff.fuseAddr    <= 3'h0;
			s_ff.loadDone    <= 1'b0;
			s_ff.rdData      <= 8'h00;
			s_ff.coreBOffset <= 12'h000;
			s_ff.gainA0      <= 5'h00;
			s_ff.gainA1      <= 5'h00;
			s_ff.gainB0      <= 5'h00;
			s_ff.gainB1      <= 5'h00;
		end else begin
			s_ff <= nxt_s;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	assign regRdData    = s_ff.rdData;
	assign fuseAddr     = s_ff.fuseAddr;
	assign fuseRd       = s_ff.fuseRd;
	assign fuseLoadDone = s_ff.loadDone;
	assign coreBOffset  = s_ff.coreBOffset;
	assign coreAGain0   = s_ff.gainA0;
	assign coreAGain1   = s_ff.gainA1;
	assign coreBGain0   = s_ff.gainB0;
	assign coreBGain1   = s_ff.gainB1;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	sequence seqFuseFetchFirst;
		fuseRd && (fuseAddr == 3'h0) && !fuseLoadDone;
	endsequence

	sequence seqWriteHi;
		regWrStrobe && fuseLoadDone && (regAddr == ADDR_OFS_INA_HI);
	endsequence

	sequence seqReadHi;
		regRdStrobe && !regWrStrobe && (regAddr == ADDR_OFS_INA_HI);
	endsequence

	AST_OFS_INA: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R1]
		(fgCalEn && !coreBInB) |=> (coreBOffset == $past(offA)))
		else $error("core B input A offset not applied");

	AST_OFS_INB: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R2]
		(fgCalEn && coreBInB) |=> (coreBOffset == $past(offB)))
		else $error("core B input B offset not applied");

	AST_OFS_MODE: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R3]
		(fgCalEn && $stable(coreBInB) && $stable(fgCalEn) &&
		$changed(dualMode) && $stable(offA) && $stable(offB))
		|=> $stable(coreBOffset))
		else $error("offset changed with channel mode");

	AST_GAIN_A: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R4]
		(fgCalEn && dualMode) |=>
		(coreAGain0 == $past(trimByte[IDX_GAIN_A0][GAIN_W-1:0])) &&
		(coreAGain1 == $past(trimByte[IDX_GAIN_A1][GAIN_W-1:0])))
		else $error("core A dual gains wrong");

	AST_GAIN_B: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R5]
		(fgCalEn && dualMode) |=>
		(coreBGain0 == $past(trimByte[IDX_GAIN_B0][GAIN_W-1:0])) &&
		(coreBGain1 == $past(trimByte[IDX_GAIN_B1][GAIN_W-1:0])))
		else $error("core B dual gains wrong");

	AST_FUSE_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R6]
		seqFuseFetchFirst ##1 1'b1 |=>
		(trimByte[IDX_OFS_INA_LO] == $past(fuseData)))
		else $error("fuse default not captured");

	AST_FUSE_DONE: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R6]
		seqFuseFetchFirst |-> ##16 fuseLoadDone)
		else $error("fuse load not finished in time");

	AST_RSVD_RW: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R7]
		seqWriteHi ##1 seqReadHi |=> (regRdData == $past(regWrData, 2)))
		else $error("reserved bits not read back");

endmodule

/* verification/trim_offset_gain_regs_tb_top.sv */
// Self-checking bench for the offset and gain trim register bank
`timescale 1ns/1ps
module trim_offset_gain_regs_tb_top;
	import trim_pkg::*;
	//------------------------------------------------------------
	// Signals
	//------------------------------------------------------------
	logic              ref_clk;
	logic              rst_b;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData;
	logic              regWrStrobe;
	logic              regRdStrobe;
	logic [DATA_W-1:0] regRdData;
	logic [2:0]        fuseAddr;
	logic              fuseRd;
	logic [DATA_W-1:0] fuseData;
	logic              fgCalEn;
	logic              dualMode;
	logic              coreBInB;
	logic [OFS_W-1:0]  coreBOffset;
	logic [GAIN_W-1:0] coreAGain0;
	logic [GAIN_W-1:0] coreAGain1;
	logic [GAIN_W-1:0] coreBGain0;
	logic [GAIN_W-1:0] coreBGain1;
	logic              fuseLoadDone;
	logic [DATA_W-1:0] rdVal;
	int                err_count;
	int                num_checks;
	int                cycleCnt;
	int                loadCnt;
	localparam logic [7:0] FUSE_ROM [8] = '{8'h12, 8'hF3, 8'h45, 8'hA6,
		8'hFB, 8'hE1, 8'h3C, 8'h7F};
	localparam logic [7:0] EXP_LOAD [8] = '{8'h12, 8'h03, 8'h45, 8'h06,
		8'h1B, 8'h01, 8'h1C, 8'h1F};

	trim_offset_gain_regs trim_offset_gain_regs_inst (
		.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStrobe(regWrStrobe),
		.regRdStrobe(regRdStrobe), .regRdData(regRdData),
		.fuseAddr(fuseAddr), .fuseRd(fuseRd), .fuseData(fuseData),
		.fgCalEn(fgCalEn), .dualMode(dualMode), .coreBInB(coreBInB),
		.coreBOffset(coreBOffset), .coreAGain0(coreAGain0),
		.coreAGain1(coreAGain1), .coreBGain0(coreBGain0),
		.coreBGain1(coreBGain1), .fuseLoadDone(fuseLoadDone));

	//------------------------------------------------------------
	// Clock, fuse storage, load counter, timeout
	//------------------------------------------------------------
	always #4 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		if (fuseRd === 1'b1) begin
			fuseData <= FUSE_ROM[fuseAddr];
		end else begin
			fuseData <= ~fuseData;
		end
	end

	always @(posedge ref_clk) begin
		if (rst_b !== 1'b1) begin
			loadCnt <= 0;
		end else if (fuseLoadDone !== 1'b1) begin
			loadCnt <= loadCnt + 1;
		end
	end

	always @(posedge ref_clk) begin
		cycleCnt <= cycleCnt + 1;
		if (cycleCnt == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end

	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge ref_clk);
		regWrStrobe <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStrobe <= 1'b1;
		@(posedge ref_clk);
		regRdStrobe <= 1'b0;
		#1;
		rdVal = regRdData;
	endtask

	// Write then read with no gap between strobes
	task automatic wr_rd(input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStrobe <= 1'b1;
		@(posedge ref_clk);
		regWrStrobe <= 1'b0;
		regRdStrobe <= 1'b1;
		@(posedge ref_clk);
		regRdStrobe <= 1'b0;
		#1;
		rdVal = regRdData;
	endtask

	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic t_fuse_load;
		repeat (10) @(posedge ref_clk);
		wr(ADDR_OFS_INA_LO, 8'hEE);
		for (int i = 0; i < 40 && fuseLoadDone !== 1'b1; i++) begin
			@(posedge ref_clk);
		end
		#1;
		check(fuseLoadDone, 1'b1);
		check(loadCnt, 16'd17);
		for (int i = 0; i < 8; i++) begin
			rd(ADDR_W'(ADDR_OFS_INA_LO + i));
			check(rdVal, EXP_LOAD[i]);
		end
		$display("test fuse_load finished");
	endtask

	task automatic t_reg_access;
		wr(ADDR_OFS_INA_HI, 8'hA5);
		rd(ADDR_OFS_INA_HI);
		check(rdVal, 8'hA5);
		@(posedge ref_clk);
		#1;
		check(regRdData, 8'h00);
		wr_rd(ADDR_OFS_INA_HI, 8'h5C);
		check(rdVal, 8'h5C);
		@(posedge ref_clk);
		#1;
		check(regRdData, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_W'(ADDR_GAIN_A0 + i), DATA_W'(8'hE0 | i));
			rd(ADDR_W'(ADDR_GAIN_A0 + i));
			check(rdVal, DATA_W'(8'hE0 | i));
		end
		wr(12'h360, 8'h5A);
		rd(12'h360);
		check(rdVal, 8'h00);
		wr(ADDR_STATUS, 8'hFE);
		rd(ADDR_STATUS);
		check(rdVal, 8'h01);
		$display("test reg_access finished");
	endtask

	task automatic t_offset;
		wr(ADDR_OFS_INA_LO, 8'hBC);
		wr(ADDR_OFS_INA_HI, 8'hFA);
		wr(ADDR_OFS_INB_LO, 8'h23);
		wr(ADDR_OFS_INB_HI, 8'h51);
		for (int m = 0; m < 4; m++) begin
			@(posedge ref_clk);
			fgCalEn <= 1'b1;
			dualMode <= m[1];
			coreBInB <= m[0];
			settle();
			check(coreBOffset, m[0] ? 12'h123 : 12'hABC);
		end
		@(posedge ref_clk);
		fgCalEn <= 1'b0;
		settle();
		check(coreBOffset, 12'h000);
		$display("test offset finished");
	endtask

	task automatic t_gain;
		wr(ADDR_GAIN_A0, 8'h11);
		wr(ADDR_GAIN_A1, 8'h0E);
		wr(ADDR_GAIN_B0, 8'h15);
		wr(ADDR_GAIN_B1, 8'h0A);
		@(posedge ref_clk);
		fgCalEn <= 1'b1;
		dualMode <= 1'b1;
		settle();
		check(coreAGain0, 5'h11);
		check(coreAGain1, 5'h0E);
		check(coreBGain0, 5'h15);
		check(coreBGain1, 5'h0A);
		@(posedge ref_clk);
		dualMode <= 1'b0;
		settle();
		check(coreAGain0, 5'h00);
		check(coreBGain1, 5'h00);
		check(coreAGain1, 5'h00);
		check(coreBGain0, 5'h00);
		@(posedge ref_clk);
		fgCalEn <= 1'b0;
		dualMode <= 1'b1;
		settle();
		check(coreAGain0, 5'h00);
		check(coreBGain0, 5'h00);
		$display("test gain finished");
	endtask

	task automatic t_reset_reload;
		@(posedge ref_clk);
		rst_b <= 1'b0;
		fgCalEn <= 1'b0;
		dualMode <= 1'b0;
		settle();
		check(fuseLoadDone, 1'b0);
		@(posedge ref_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 40 && fuseLoadDone !== 1'b1; i++) begin
			@(posedge ref_clk);
		end
		#1;
		check(loadCnt, 16'd17);
		rd(ADDR_OFS_INA_HI);
		check(rdVal, EXP_LOAD[IDX_OFS_INA_HI]);
		rd(ADDR_GAIN_B1);
		check(rdVal, EXP_LOAD[IDX_GAIN_B1]);
		$display("test reset_reload finished");
	endtask

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		regAddr = '0;
		regWrData = '0;
		regWrStrobe = 1'b0;
		regRdStrobe = 1'b0;
		fuseData = '0;
		fgCalEn = 1'b0;
		dualMode = 1'b0;
		coreBInB = 1'b0;
		err_count = 0;
		num_checks = 0;
		cycleCnt = 0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_fuse_load();
		t_reg_access();
		t_offset();
		t_gain();
		t_reset_reload();
		tally_and_finish();
	end
endmodule
